/* i2c_slave_addr_mask.sv */
`timescale 1ns/1ps
// i2c slave address matcher with wishbone registers
module i2c_slave_addr_mask (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_mask_cfg,   // mask_scheme_config_bit, 1 = unprogrammed
  input  wire logic        i_cyc,
  input  wire logic        i_stb,
  input  wire logic        i_we,
  input  wire logic [13:0] i_adr,
  input  wire logic [3:0]  i_sel,
  input  wire logic [31:0] i_dat,
  output logic      [31:0] o_dat,
  output logic             o_ack,
  output logic             o_irq,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_scl_oe,     // pulls scl low
  output logic             o_sda_oe,     // pulls sda low
  output logic             o_scl_o,
  output logic             o_sda_o
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,  // waiting for start
    ST_ADDR = 3'b001,  // shifting address
    ST_ACK  = 3'b010,  // driving acknowledge
    ST_DATA = 3'b011,  // receiving data
    ST_SKIP = 3'b100   // not addressed
  } st_t;
  st_t        st_r;
  logic       scl_s, sda_s;           // synchronised pins
  logic       scl_d_r, sda_d_r;       // previous samples
  logic       scl_rise, scl_fall, start_c, stop_c;
  logic [7:0] shift_r;                // serial_shift_reg
  logic [3:0] bit_r;                  // clocks in this byte
  logic       first_r;                // next byte is first after start
  logic [7:0] ctrl2_r;                // second_control_reg
  logic [7:0] own_r;                  // own_address_reg
  logic [7:0] fmask_r;                // address_mask_reg
  logic [7:0] buf_r;                  // serial_buffer_reg
  logic [2:0] cfg_r;                  // enable, ten-bit, mask select
  logic [2:0] stat_r, en_r;           // interrupt status and enable
  logic [2:0] ev;                     // events this cycle
  logic       hit, gcall, hold_r, acking_r;
  logic       wr, rd;
  logic [11:0] idx;
  logic       scheme5;
  assign scheme5 = ~i_mask_cfg;
  assign idx     = i_adr[13:2];
  assign wr      = i_cyc & i_stb & i_we & i_sel[0] & ~o_ack;
  assign rd      = i_cyc & i_stb & ~o_ack;
  // ----------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------
  sync2 u_scl (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_d(i_scl), .o_q(scl_s));
  sync2 u_sda (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_d(i_sda), .o_q(sda_s));
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;
  // ----------------------------------------
  // address compare
  // ----------------------------------------
  addr_match u_match (
    .i_scheme5   (scheme5),
    .i_ten       (cfg_r[addr_mask_pkg::B_CFG_TEN] & ~first_r),
    .i_own       (own_r),
    .i_full_mask (fmask_r),
    .i_up_mask   (ctrl2_r[5:1]),
    .i_rx        (shift_r),
    .o_hit       (hit)
  );
  // general call: first seven-bit byte only, so a ten-bit low byte of zero is not taken
  assign gcall = ctrl2_r[addr_mask_pkg::B_GENERAL_CALL_ENABLE] && first_r && !cfg_r[addr_mask_pkg::B_CFG_TEN] &&
                 (shift_r == addr_mask_pkg::GCALL_ADDR);
  // ----------------------------------------
  // bus state machine
  // ----------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n || !cfg_r[addr_mask_pkg::B_CFG_EN])
    begin
      st_r    <= ST_IDLE;
      bit_r   <= 4'h0;
      shift_r <= 8'h00;
      first_r <= 1'b1;
    end
    else if (stop_c)
      st_r <= ST_IDLE;
    else if (start_c)
    begin
      st_r    <= ST_ADDR;
      bit_r   <= 4'h0;
      first_r <= 1'b1;
    end
    else if (scl_rise && st_r != ST_IDLE && st_r != ST_ACK)
    begin
      shift_r <= {shift_r[6:0], sda_s};
      bit_r   <= bit_r + 4'h1;
    end
    else if (scl_fall && bit_r == addr_mask_pkg::CLK_NINTH)
    begin
      bit_r <= 4'h0;
      unique case (st_r)
        ST_ADDR:
        begin
          // ten-bit header: prefix bits then own high bits
          if (cfg_r[addr_mask_pkg::B_CFG_TEN] && first_r)
            st_r <= (shift_r[7:3] == addr_mask_pkg::TEN_HDR &&
                     shift_r[2:1] == own_r[7:6]) ? ST_ACK : ST_SKIP;
          else
            st_r <= (hit || gcall) ? ST_ACK : ST_SKIP;
        end
        ST_DATA: st_r <= ST_ACK;
        default: st_r <= st_r;
      endcase
    end
    else if (scl_fall && st_r == ST_ACK)
    begin
      // after a ten-bit header the low byte follows as address
      st_r    <= (cfg_r[addr_mask_pkg::B_CFG_TEN] && first_r) ? ST_ADDR : ST_DATA;
      first_r <= 1'b0;
    end
  end
  // ----------------------------------------
  // acknowledge drive and clock stretch
  // ----------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      acking_r <= 1'b0;
      hold_r   <= 1'b0;
    end
    else
    begin
      acking_r <= (st_r == ST_ACK);
      // hold scl low after ack until software reads buffer
      if (scl_fall && st_r == ST_ACK && ctrl2_r[addr_mask_pkg::B_STRETCH])
        hold_r <= 1'b1;
      else if ((rd && !i_we && idx == addr_mask_pkg::IDX_BUF) || st_r == ST_IDLE)
        hold_r <= 1'b0;
    end
  end
  assign o_sda_o  = 1'b0;
  assign o_scl_o  = 1'b0;
  assign o_sda_oe = acking_r;
  assign o_scl_oe = hold_r;
  // ----------------------------------------
  // events into buffer
  // ----------------------------------------
  always_comb
  begin
    ev = 3'b000;
    if (scl_fall && bit_r == addr_mask_pkg::CLK_NINTH && !start_c && !stop_c)
    begin
      ev[addr_mask_pkg::B_EV_MATCH] = (st_r == ST_ADDR) && hit && !(cfg_r[addr_mask_pkg::B_CFG_TEN] && first_r);
      ev[addr_mask_pkg::B_EV_GCALL] = (st_r == ST_ADDR) && gcall;
      ev[addr_mask_pkg::B_EV_DATA]  = (st_r == ST_DATA);
    end
  end
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      buf_r <= addr_mask_pkg::RST_ZERO;
    else if (|ev)
      buf_r <= shift_r;
    else if (wr && idx == addr_mask_pkg::IDX_BUF && !cfg_r[addr_mask_pkg::B_CFG_EN])
      buf_r <= i_dat[7:0];
  end
  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      ctrl2_r <= addr_mask_pkg::RST_ZERO;
      own_r   <= addr_mask_pkg::RST_ZERO;
      fmask_r <= addr_mask_pkg::RST_MASK;
      cfg_r   <= 3'b000;
      en_r    <= 3'b000;
    end
    else if (wr)
    begin
      unique case (idx)
        addr_mask_pkg::IDX_CTRL2:
        begin
          ctrl2_r[7:1] <= {i_dat[7], ctrl2_r[6], i_dat[5:1]};
          // stretch bit may only be cleared while active
          ctrl2_r[0] <= cfg_r[addr_mask_pkg::B_CFG_EN] ? (ctrl2_r[0] & i_dat[0]) : i_dat[0];
        end
        addr_mask_pkg::IDX_ADDR:
          if (cfg_r[addr_mask_pkg::B_CFG_MSKSEL] && !scheme5)
            fmask_r <= i_dat[7:0];
          else
            own_r <= i_dat[7:0];
        addr_mask_pkg::IDX_CFG:    cfg_r <= i_dat[2:0];
        addr_mask_pkg::IDX_IRQ_EN: en_r  <= i_dat[2:0];
        default: ;
      endcase
    end
  end
  // ----------------------------------------
  // sticky status, set wins over clear
  // ----------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      stat_r <= 3'b000;
    else if (wr && idx == addr_mask_pkg::IDX_IRQ_CLR)
      stat_r <= (stat_r & ~i_dat[2:0]) | ev;
    else
      stat_r <= stat_r | ev;
  end
  assign o_irq = |(stat_r & en_r);
  // ----------------------------------------
  // read data and ack
  // ----------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_ack <= 1'b0;
      o_dat <= 32'h0000_0000;
    end
    else
    begin
      o_ack <= rd;
      o_dat <= 32'h0000_0000;
      if (rd)
        unique case (idx)
          addr_mask_pkg::IDX_CTRL2:    o_dat[7:0] <= ctrl2_r;
          addr_mask_pkg::IDX_ADDR:     o_dat[7:0] <= (cfg_r[addr_mask_pkg::B_CFG_MSKSEL] && !scheme5) ? fmask_r : own_r;
          addr_mask_pkg::IDX_BUF:      o_dat[7:0] <= buf_r;
          addr_mask_pkg::IDX_CFG:      o_dat[2:0] <= cfg_r;
          addr_mask_pkg::IDX_IRQ_STAT: o_dat[2:0] <= stat_r;
          addr_mask_pkg::IDX_IRQ_EN:   o_dat[2:0] <= en_r;
          default:                     o_dat <= 32'h0000_0000;
        endcase
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_ack_one;
    @(posedge i_mclk) disable iff (!i_rst_n) o_ack |=> !o_ack;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");
  // irq may only rise after an event or an enable write
  property p_irq;
    @(posedge i_mclk) disable iff (!i_rst_n)
      $rose(o_irq) |-> $past(|ev) || $past(wr && idx == addr_mask_pkg::IDX_IRQ_EN);
  endproperty
  a_irq: assert property (p_irq) else $error("irq not from status");
  property p_buf_load;
    @(posedge i_mclk) disable iff (!i_rst_n) |ev |=> buf_r == $past(shift_r);
  endproperty
  a_buf_load: assert property (p_buf_load) else $error("buffer missed byte");
  property p_gc_off;
    @(posedge i_mclk) disable iff (!i_rst_n) !ctrl2_r[addr_mask_pkg::B_GENERAL_CALL_ENABLE] |-> !ev[addr_mask_pkg::B_EV_GCALL];
  endproperty
  a_gc_off: assert property (p_gc_off) else $error("general call while disabled");
  property p_no_stretch;
    @(posedge i_mclk) disable iff (!i_rst_n) !ctrl2_r[addr_mask_pkg::B_STRETCH] && !hold_r |=> !hold_r;
  endproperty
  a_no_stretch: assert property (p_no_stretch) else $error("stretch while disabled");
  property p_sen_blocked;
    @(posedge i_mclk) disable iff (!i_rst_n)
      cfg_r[addr_mask_pkg::B_CFG_EN] && !ctrl2_r[0] |=> !ctrl2_r[0];
  endproperty
  a_sen_blocked: assert property (p_sen_blocked) else $error("stretch set while active");
  property p_stat_sticky;
    @(posedge i_mclk) disable iff (!i_rst_n)
      stat_r[0] && !(wr && idx == addr_mask_pkg::IDX_IRQ_CLR) |=> stat_r[0];
  endproperty
  a_stat_sticky: assert property (p_stat_sticky) else $error("status lost");
  property p_match_ack;
    @(posedge i_mclk) disable iff (!i_rst_n) ev[addr_mask_pkg::B_EV_MATCH] |=> st_r == ST_ACK;
  endproperty
  a_match_ack: assert property (p_match_ack) else $error("match not acknowledged");
  // ----------------------------------------
  // acknowledge and header sequences
  // ----------------------------------------
  // an address event this cycle
  sequence s_addr_taken;
    ev[addr_mask_pkg::B_EV_MATCH] || ev[addr_mask_pkg::B_EV_GCALL];
  endsequence
  // sda pulled low once the ack state has been registered
  sequence s_ack_driven;
    ##2 o_sda_oe;
  endsequence
  property p_ack_drive;
    @(posedge i_mclk) disable iff (!i_rst_n) s_addr_taken |-> s_ack_driven;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("address taken but sda not pulled");
  // end of a ten-bit header byte
  sequence s_header_end;
    cfg_r[addr_mask_pkg::B_CFG_EN] && cfg_r[addr_mask_pkg::B_CFG_TEN] && first_r && st_r == ST_ADDR &&
    scl_fall && bit_r == addr_mask_pkg::CLK_NINTH && !start_c && !stop_c;
  endsequence
  property p_header_high;
    @(posedge i_mclk) disable iff (!i_rst_n)
      s_header_end |=> (st_r == ST_ACK) == ($past(shift_r[2:1]) == $past(own_r[7:6]) &&
                                            $past(shift_r[7:3]) == addr_mask_pkg::TEN_HDR);
  endproperty
  a_header_high: assert property (p_header_high) else $error("ten-bit header high bits masked");
  // match event stored next cycle, set wins
  property p_stat_set;
    @(posedge i_mclk) disable iff (!i_rst_n) ev[addr_mask_pkg::B_EV_MATCH] |=> stat_r[addr_mask_pkg::B_EV_MATCH];
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("match event not stored");
  // buffer writes have no effect while the module is active
  property p_buf_locked;
    @(posedge i_mclk) disable iff (!i_rst_n)
      wr && idx == addr_mask_pkg::IDX_BUF && cfg_r[addr_mask_pkg::B_CFG_EN] && !(|ev) |=> $stable(buf_r);
  endproperty
  a_buf_locked: assert property (p_buf_locked) else $error("buffer written while active");
  // every taken request is answered in the next cycle
  property p_answer;
    @(posedge i_mclk) disable iff (!i_rst_n) rd |=> o_ack;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  // a buffer read releases a held clock
  property p_hold_release;
    @(posedge i_mclk) disable iff (!i_rst_n)
      hold_r && rd && !i_we && idx == addr_mask_pkg::IDX_BUF && !scl_fall |=> !hold_r;
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("clock hold not released");
endmodule : i2c_slave_addr_mask

/* addr_mask_pkg.sv */
// Overview of operation
// - acknowledge when all unmasked bits match
// - ten-bit: upper field masks bits 5:2
// - low pair bit masks 1:0 or 1
// - ten-bit upper address bits never masked
// - five-bit scheme masks only bits 5..1, and bit 0 in ten-bit
// - second control register holds mask in slave
// - config bit zero selects five-bit scheme
// - unprogrammed config defaults to full mask scheme
// - full mask: set bit don't-care, clear exact
// - seven-bit addressing ignores mask bit zero
// - mask register shares own-address offset
// - every address matching unmasked bits accepted
// - received address byte lands in buffer
// - both schemes serve seven and ten bit
// - active module blocks stretch set, buffer writes
package addr_mask_pkg;
  // ----------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [11:0] IDX_CTRL2    = 12'hFC5; // second control / five-bit mask
  localparam logic [11:0] IDX_ADDR     = 12'hFC8; // own address, or full mask when selected
  localparam logic [11:0] IDX_BUF      = 12'hFC9; // serial buffer
  localparam logic [11:0] IDX_CFG      = 12'hFCA; // enable, mode and mask select config
  localparam logic [11:0] IDX_IRQ_STAT = 12'hFCB; // sticky events, read only
  localparam logic [11:0] IDX_IRQ_EN   = 12'hFCC; // interrupt enables
  localparam logic [11:0] IDX_IRQ_CLR  = 12'hFCD; // write one to clear
  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int          B_GENERAL_CALL_ENABLE       = 7;       // general_call_enable
  localparam int          B_STRETCH    = 0;       // stretch_enable
  localparam int          B_CFG_EN     = 0;       // module enable
  localparam int          B_CFG_TEN    = 1;       // ten-bit addressing
  localparam int          B_CFG_MSKSEL = 2;       // expose mask register at shared index
  localparam int          B_EV_MATCH   = 0;       // address match event
  localparam int          B_EV_GCALL   = 1;       // general call event
  localparam int          B_EV_DATA    = 2;       // data byte event
  localparam logic [7:0]  RST_MASK     = 8'hFF;
  localparam logic [7:0]  RST_ZERO     = 8'h00;
  localparam logic [7:0]  GCALL_ADDR   = 8'h00;
  localparam logic [4:0]  TEN_HDR      = 5'h1E;   // 11110 prefix of ten-bit header
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [3:0]  CLK_NINTH    = 4'h8;
endpackage : addr_mask_pkg

/* sync2.sv */
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs
module sync2 (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_d,
  output logic      o_q
);
  logic meta_r; // first stage, read only by second stage
  // ----------------------------------------
  // synchroniser chain
  // ----------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      meta_r <= 1'b1;
      o_q    <= 1'b1;
    end
    else
    begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end
endmodule : sync2

/* addr_match.sv */
`timescale 1ns/1ps
// combinational address compare with both mask schemes
module addr_match (
  input  wire logic       i_scheme5,   // 1 = five-bit scheme
  input  wire logic       i_ten,       // ten-bit addressing
  input  wire logic [7:0] i_own,       // own_address_reg
  input  wire logic [7:0] i_full_mask, // full_mask_bits
  input  wire logic [4:0] i_up_mask,   // upper_mask_field bits 5:1
  input  wire logic [7:0] i_rx,        // received address byte
  output logic            o_hit
);
  logic [7:0] care; // one where the bit must match
  // ----------------------------------------
  // effective mask
  // ----------------------------------------
  always_comb
  begin
    care = 8'hFF;
    if (i_scheme5)
    begin
      care[5:2] = ~i_up_mask[4:1];
      if (i_ten)
        care[1:0] = {2{~i_up_mask[0]}};
      else
        care[1] = ~i_up_mask[0];
    end
    else
    begin
      care = ~i_full_mask;
      if (!i_ten)
        care[0] = 1'b1;
    end
    if (!i_ten)
      care[0] = 1'b0;                         // r/w bit in seven-bit byte
  end
  // unmasked bits equal
  assign o_hit = ((i_rx ^ i_own) & care) == 8'h00;
endmodule : addr_match

/* i2c_master_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// i2c bus master driving the slave pins
// ----------------------------------------
module i2c_master_model (
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl_oe,
  output logic      o_sda_oe,
  output logic      o_done,
  output logic      o_ack
);
  // released lines float high through the pull-up; scl idles high between frames
  initial
  begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
    o_done   = 1'b0;
    o_ack    = 1'b0;
  end
  // one 64 ns bit; a stretched clock is waited out, boundedly
  task automatic bit_clk(input logic b, output logic s);
    #16;
    o_sda_oe = ~b;
    #16;
    o_scl_oe = 1'b0;
    for (int k = 0; k < 400 && !i_scl; k++)
      #5;
    #16;
    s = i_sda;
    #16;
    o_scl_oe = 1'b1;
  endtask : bit_clk
  // eight bits msb first, then the acknowledge clock
  task automatic byte_out(input logic [7:0] b, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_clk(b[i], s);
    bit_clk(1'b1, s);
    a = ~s;
  endtask : byte_out
  // start, one or two bytes, stop; o_done pulses with the last acknowledge
  task automatic xfer(input logic [7:0] b0, input logic two, input logic [7:0] b1);
    logic a;
    o_sda_oe = 1'b1;
    #32;
    o_scl_oe = 1'b1;
    byte_out(b0, a);
    if (two && a)
      byte_out(b1, a);
    #16;
    o_sda_oe = 1'b1;
    #16;
    o_scl_oe = 1'b0;
    for (int k = 0; k < 400 && !i_scl; k++)
      #5;
    #16;
    o_sda_oe = 1'b0;
    o_ack    = a;
    o_done   = 1'b1;
    #20;
    o_done   = 1'b0;
  endtask : xfer
endmodule : i2c_master_model

/* i2c_slave_address_masking_bench.sv */
`timescale 1ns/1ps
module i2c_slave_address_masking_bench;
  // ----------------------------------------
  // signals and models
  // ----------------------------------------
  logic        i_mclk;
  logic        i_rst_n;
  logic        strap;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [13:0] adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        irq;
  logic        d_scl_oe;
  logic        d_sda_oe;
  logic        m_scl_oe;
  logic        m_sda_oe;
  logic        m_done;
  logic        m_ack;
  wire         scl_w = ~(d_scl_oe | m_scl_oe); // open drain, pulled up
  wire         sda_w = ~(d_sda_oe | m_sda_oe);
  logic [7:0]  eq[$];                          // expected read bytes
  logic [7:0]  mq[$];                          // read compare masks
  logic        aq[$];                          // expected acknowledges
  int          bad_count;
  int          checked;
  int          seed;
  logic [7:0]  own_m;                          // modelled own address
  logic [7:0]  msk_m;                          // modelled full mask
  logic [7:0]  c2_m;                           // modelled second control
  logic        ten_m;                          // ten-bit addressing
  int          hold_n;                         // cycles waited for a clock hold
  i2c_slave_addr_mask dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_mask_cfg(strap), .i_cyc(cyc), .i_stb(stb),
    .i_we(we), .i_adr(adr), .i_sel(4'hF), .i_dat(wdat), .o_dat(rdat), .o_ack(ack), .o_irq(irq), .i_scl(scl_w),
    .i_sda(sda_w), .o_scl_oe(d_scl_oe), .o_sda_oe(d_sda_oe), .o_scl_o(), .o_sda_o());
  i2c_master_model pm_u (.i_scl(scl_w), .i_sda(sda_w), .o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe),
    .o_done(m_done), .o_ack(m_ack));
  // 200 MHz clock
  always #2.5 i_mclk = ~i_mclk;
  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : cmp8
  // read data against the oldest note
  always @(posedge i_mclk)
  begin
    if (ack === 1'b1 && !we && eq.size() > 0)
      cmp8("read data", eq.pop_front(), rdat[7:0] & mq.pop_front());
  end
  // address acknowledge against the oldest note
  always @(posedge m_done)
  begin
    if (aq.size() > 0)
      cmp8("address ack", {7'h00, aq.pop_front()}, {7'h00, m_ack});
  end
  // one classic cycle; waits for ack under a bound
  task automatic bus(input logic w, input logic [11:0] x, input logic [7:0] d, input logic [7:0] m,
                     input logic [7:0] e);
    int n;
    @(posedge i_mclk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {x, 2'b00};
    wdat <= {24'h000000, d};
    if (!w)
    begin
      eq.push_back(e);
      mq.push_back(m);
    end
    n = 0;
    do
    begin
      @(posedge i_mclk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
    begin
      bad_count++;
      report_and_stop();
    end
  endtask : bus
  task automatic wr(input logic [11:0] x, input logic [7:0] d);
    bus(1'b1, x, d, 8'h00, 8'h00);
  endtask : wr
  task automatic rd(input logic [11:0] x, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, x, 8'h00, m, e);
  endtask : rd
  // irq level once the last write has landed
  task automatic chk_irq(input logic e);
    repeat (2) @(negedge i_mclk);
    cmp8("irq", {7'h00, e}, {7'h00, irq});
  endtask : chk_irq
  // expected acceptance of an address byte
  function automatic logic hit(input logic [7:0] rx);
    logic [7:0] m;
    if (strap)
      m = ten_m ? msk_m : (msk_m | 8'h01);
    else
      m = ten_m ? {2'b00, c2_m[5:2], {2{c2_m[1]}}} : {2'b00, c2_m[5:1], 1'b1};
    if (!ten_m && rx[7:1] == 7'h00)
      return c2_m[7];
    return ((rx ^ own_m) & ~m) == 8'h00;
  endfunction : hit
  // one addressing attempt, then status and buffer
  task automatic probe(input logic [7:0] rx);
    logic h;
    logic g;
    h = hit(rx);
    g = !ten_m && rx[7:1] == 7'h00;
    aq.push_back(h);
    pm_u.xfer(ten_m ? {5'h1E, own_m[7:6], 1'b0} : rx, ten_m, rx);
    repeat (8) @(posedge i_mclk);
    rd(addr_mask_pkg::IDX_IRQ_STAT, g ? 8'h02 : 8'h03, h ? (g ? 8'h02 : 8'h01) : 8'h00);
    if (h)
      rd(addr_mask_pkg::IDX_BUF, 8'hFF, rx);
    wr(addr_mask_pkg::IDX_IRQ_CLR, 8'h07);
  endtask : probe
  // fixed masked addresses plus random ones
  task automatic sweep;
    logic [31:0] r;
    for (int k = 0; k < 8; k++)
      probe(8'hA0 | 8'(k << 1));
    for (int k = 0; k < 10; k++)
    begin
      r = $random(seed);
      probe((r[0] ? (own_m ^ (r[15:8] & 8'h3F)) : r[15:8]) & {7'h7F, ten_m});
    end
    probe(8'hB0);
  endtask : sweep
  task automatic do_reset(input logic s);
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    strap   <= s;
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    own_m = 8'h00;
    msk_m = 8'hFF;
    c2_m  = 8'h00;
    ten_m = 1'b0;
  endtask : do_reset
  // run seven and ten bit under the current scheme
  task automatic both_modes;
    wr(addr_mask_pkg::IDX_ADDR, 8'hA0);
    own_m = 8'hA0;
    wr(addr_mask_pkg::IDX_CFG, 8'h01);
    sweep();
    wr(addr_mask_pkg::IDX_CFG, 8'h03);
    ten_m = 1'b1;
    sweep();
    wr(addr_mask_pkg::IDX_CFG, 8'h01);
    ten_m = 1'b0;
  endtask : both_modes
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    i_mclk    = 1'b0;
    i_rst_n   = 1'b0;
    strap     = 1'b1;
    cyc       = 1'b0;
    stb       = 1'b0;
    we        = 1'b0;
    adr       = 14'h0000;
    wdat      = 32'h00000000;
    bad_count = 0;
    checked   = 0;
    seed      = 32'hB3CC;
    do_reset(1'b1);
    rd(addr_mask_pkg::IDX_CTRL2, 8'hFF, 8'h00);
    rd(addr_mask_pkg::IDX_ADDR, 8'hFF, 8'h00);
    wr(addr_mask_pkg::IDX_CFG, 8'h04);
    rd(addr_mask_pkg::IDX_ADDR, 8'hFF, 8'hFF);
    wr(addr_mask_pkg::IDX_ADDR, 8'h0E);
    msk_m = 8'h0E;
    wr(addr_mask_pkg::IDX_CFG, 8'h00);
    rd(12'hFCE, 8'hFF, 8'h00);
    both_modes();
    rd(addr_mask_pkg::IDX_ADDR, 8'hFF, 8'hA0);
    // interrupt raised, masked, cleared
    wr(addr_mask_pkg::IDX_IRQ_EN, 8'h01);
    aq.push_back(1'b1);
    pm_u.xfer(8'hA6, 1'b0, 8'h00);
    chk_irq(1'b1);
    wr(addr_mask_pkg::IDX_IRQ_EN, 8'h00);
    chk_irq(1'b0);
    wr(addr_mask_pkg::IDX_IRQ_EN, 8'h01);
    chk_irq(1'b1);
    wr(addr_mask_pkg::IDX_IRQ_CLR, 8'h01);
    chk_irq(1'b0);
    // general call on and off, blocked writes while active
    wr(addr_mask_pkg::IDX_CTRL2, 8'h81);
    c2_m = 8'h80;
    rd(addr_mask_pkg::IDX_CTRL2, 8'h81, 8'h80);
    probe(8'h00);
    wr(addr_mask_pkg::IDX_BUF, 8'h55);
    rd(addr_mask_pkg::IDX_BUF, 8'hFF, 8'h00);
    wr(addr_mask_pkg::IDX_CTRL2, 8'h00);
    c2_m = 8'h00;
    probe(8'h00);
    // five-bit scheme after a second reset
    do_reset(1'b0);
    wr(addr_mask_pkg::IDX_CTRL2, 8'h0E);
    c2_m = 8'h0E;
    both_modes();
    rd(addr_mask_pkg::IDX_CTRL2, 8'h3E, 8'h0E);
    // clock held after the address until the buffer is read
    wr(addr_mask_pkg::IDX_CFG, 8'h00);
    wr(addr_mask_pkg::IDX_CTRL2, 8'h0F);
    c2_m = 8'h0F;
    wr(addr_mask_pkg::IDX_CFG, 8'h01);
    aq.push_back(1'b1);
    fork
      pm_u.xfer(8'hA4, 1'b0, 8'h00);
      begin
        hold_n = 0;
        while (d_scl_oe !== 1'b1 && hold_n < 400)
        begin
          @(posedge i_mclk);
          hold_n++;
        end
        cmp8("scl hold", 8'h01, {7'h00, d_scl_oe});
        rd(addr_mask_pkg::IDX_BUF, 8'hFF, 8'hA4);
      end
    join
    report_and_stop();
  end
endmodule : i2c_slave_address_masking_bench
